// File: cache_config_and_maintenance_test.sv
`timescale 1ns/10ps

module cache_config_and_maintenance_test;
    logic CLK, RST_N, REG_WR, REG_RD, REG_STALL, WRAP_TO_INCR, SYNC_DRAIN, fill;
    logic LKP_REQ, LKP_ACK, LKP_VALID, LKP_DIRTY, WB_REQ, WB_ACK;
    logic UPD_STB, UPD_CLR_VALID, UPD_CLR_DIRTY, sb_empty, eb_empty, wa_empty;
    logic [3:0] REG_SUB, nways, ibits, delay;
    logic [31:0] REG_WDATA, REG_RDATA, a, d;
    logic [2:0] dlat, tlat, wlat, rlat, wsz, ew;
    logic [7:0] alloc_lock;
    logic cl, inv, pa;
    ccm_pkg::ccm_lkp_s LKP_CMD;
    int n_errors, n_compared, i, s, k, c0, w0, u0;

    ccm_top uut (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_SUB(REG_SUB), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_STALL(REG_STALL), .DIRTY_RAM_LATENCY_OUT(dlat), .TAG_RAM_LATENCY_OUT(tlat),
        .DATA_RAM_WRITE_LATENCY_OUT(wlat), .DATA_RAM_READ_LATENCY_OUT(rlat),
        .WRAP_TO_INCR(WRAP_TO_INCR), .WAY_SIZE_SEL(wsz), .NUM_WAYS(nways),
        .INDEX_BITS(ibits), .ALLOC_LOCK(alloc_lock), .STORE_BUFFER_EMPTY(sb_empty),
        .EVICTION_BUFFER_EMPTY(eb_empty), .WRITE_ALLOCATE_BUFFER_EMPTY(wa_empty),
        .SYNC_DRAIN(SYNC_DRAIN), .LKP_REQ(LKP_REQ), .LKP_CMD(LKP_CMD), .LKP_ACK(LKP_ACK),
        .LKP_VALID(LKP_VALID), .LKP_DIRTY(LKP_DIRTY), .WB_REQ(WB_REQ), .WB_ACK(WB_ACK),
        .UPD_STB(UPD_STB), .UPD_CLR_VALID(UPD_CLR_VALID), .UPD_CLR_DIRTY(UPD_CLR_DIRTY));

    ccm_bus_partner far (.CLK(CLK), .RST_N(RST_N), .delay(delay), .fill(fill),
        .SYNC_DRAIN(SYNC_DRAIN), .LKP_REQ(LKP_REQ), .LKP_CMD(LKP_CMD), .WB_REQ(WB_REQ),
        .UPD_STB(UPD_STB), .UPD_CLR_VALID(UPD_CLR_VALID), .UPD_CLR_DIRTY(UPD_CLR_DIRTY),
        .LKP_ACK(LKP_ACK), .LKP_VALID(LKP_VALID), .LKP_DIRTY(LKP_DIRTY), .WB_ACK(WB_ACK),
        .STORE_BUFFER_EMPTY(sb_empty), .EVICTION_BUFFER_EMPTY(eb_empty),
        .WRITE_ALLOCATE_BUFFER_EMPTY(wa_empty));

    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask

    task step;
        @(posedge CLK);
        #1;
    endtask

    task wr(input logic [3:0] sub, input logic [31:0] data);
        step();
        REG_WR = 1'b1;
        REG_SUB = sub;
        REG_WDATA = data;
        step();
        REG_WR = 1'b0;
    endtask

    task rd(input logic [3:0] sub, output logic [31:0] data);
        step();
        REG_RD = 1'b1;
        REG_SUB = sub;
        step();
        REG_RD = 1'b0;
        data = REG_RDATA;
    endtask

    // Bounded wait for the stall to drop; k returns the cycles spent
    task wait_stall(input int lim);
        for (k = 0; k < lim && REG_STALL !== 1'b0; k++)
            step();
        if (k == lim)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask

    task snap;
        c0 = far.n_lkp;
        w0 = far.n_wb;
        u0 = far.n_upd;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {REG_WR, REG_RD, REG_SUB, REG_WDATA, fill, delay} = '0;
        n_errors = 0;
        n_compared = 0;
        RST_N = 1'b0;
        repeat (10) @(posedge CLK);
        #1 RST_N = 1'b1;
        rd(4'h0, d);
        check("aux reset", d, 32'h0002_0fff);
        check("lat reset", {dlat, tlat, wlat, rlat}, 32'h0000_0fff);
        check("ways reset", nways, 32'h0);
        check("reset outs", {REG_STALL, alloc_lock}, 32'h0);

        // Every way size and associativity code, with varied latency fields
        for (i = 0; i < 16; i++)
        begin
            a = 32'hfe00_0000 | (i << 17) | (i << 13) | (i[0] << 12);
            a[11:0] = {i[2:0], ~i[2:0], i[2:0] + 3'h1, 3'h7 - i[2:0]};
            wr(4'h0, a);
            ew = (i[2:0] < 2) ? 3'h0 : (i[2:0] > 5) ? 3'h4 : i[2:0] - 3'h1;
            check("way size", wsz, ew);
            check("index bits", ibits, 32'h9 + ew);
            check("num ways", nways, (i > 8) ? 8 : i);
            check("wrap", WRAP_TO_INCR, i[0]);
            check("lat outs", {dlat, tlat, wlat, rlat}, a[11:0]);
            rd(4'h0, d);
            check("aux read", d, a & 32'h01ff_ffff);
        end

        // Sync waits for the store buffer, which empties last
        wr(4'h0, 32'h0003_0fff);
        delay = 4'h5;
        step();
        fill = 1'b1;
        step();
        fill = 1'b0;
        wr(4'h1, 32'h0);
        check("sync stall", REG_STALL, 1);
        check("sync drain", SYNC_DRAIN, 1);
        wait_stall(50);
        check("sync length", k, 6);
        check("store empty", sb_empty, 1);

        // Line ops: every line code against every valid/dirty pairing, slow answers
        delay = 4'h2;
        for (s = 2; s < 7; s++)
            for (i = 0; i < 4; i++)
            begin
                cl = s != 2;
                inv = s == 2 || s == 5 || s == 6;
                pa = s[0] == 1'b0;
                a = 32'h1234_4000 | (i << 6);
                if (!pa)
                    a[31:29] = 3'h0;
                snap();
                wr(s, a);
                check("line stall", REG_STALL, 1);
                check("line sync", SYNC_DRAIN, 1);
                wait_stall(100);
                check("lookups", far.n_lkp - c0, 1);
                check("by pa", far.last_cmd.by_pa, pa);
                check("line addr", far.last_cmd.addr, a);
                check("wback", far.n_wb - w0, cl && i == 3);
                check("update", far.n_upd - u0, (inv && i[0]) || (cl && i == 3));
                if (far.n_upd != u0)
                    check("upd bits", {far.last_cv, far.last_cd}, {inv, cl});
            end
        rd(4'h4, d);
        check("line subreg", d, 32'h0);

        // Way ops on one real way plus one absent way; a sync asked meanwhile is dropped
        delay = 4'h0;
        wr(4'h0, 32'h0002_2fff);
        for (s = 7; s < 10; s++)
        begin
            snap();
            wr(s, 32'h0000_0003);
            check("way stall", REG_STALL, 0);
            check("way sync", SYNC_DRAIN, 1);
            check("lock", alloc_lock, 32'h3);
            rd(s, d);
            check("way bits", d[7:0], 32'h3);
            wr(4'h1, 32'h0);
            check("ignored", REG_STALL, 0);
            for (k = 0; k < 5000 && d[7:0] !== 8'h00; k++)
                rd(s, d);
            if (k == 5000)
            begin
                n_errors++;
                report_and_stop();
            end
            check("unlock", alloc_lock, 32'h0);
            check("way lkp", far.n_lkp - c0, 512);
            check("way wb", far.n_wb - w0, (s == 7) ? 0 : 128);
            check("way upd", far.n_upd - u0, (s == 8) ? 128 : 256);
            check("way last", far.last_cmd.addr, 32'h0000_3fe0);
        end

        // Invalidate all with no ways configured selects every way, no lookups
        wr(4'h0, 32'h0002_0fff);
        snap();
        wr(4'ha, 32'h0);
        check("inv all", alloc_lock, 32'hff);
        for (k = 0; k < 100 && alloc_lock !== 8'h00; k++)
            step();
        check("inv all end", alloc_lock, 32'h0);
        check("inv all lkp", far.n_lkp - c0, 0);
        report_and_stop();
    end
endmodule

// File: ccm_bus_partner.sv
`timescale 1ns/10ps

module ccm_bus_partner (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [3:0] delay,
    input wire logic fill,
    input wire logic SYNC_DRAIN,
    input wire logic LKP_REQ,
    input wire ccm_pkg::ccm_lkp_s LKP_CMD,
    input wire logic WB_REQ,
    input wire logic UPD_STB,
    input wire logic UPD_CLR_VALID,
    input wire logic UPD_CLR_DIRTY,
    output logic LKP_ACK,
    output logic LKP_VALID,
    output logic LKP_DIRTY,
    output logic WB_ACK,
    output logic STORE_BUFFER_EMPTY,
    output logic EVICTION_BUFFER_EMPTY,
    output logic WRITE_ALLOCATE_BUFFER_EMPTY
);
    logic [3:0] wait_q;
    logic [3:0] fill_q;
    int n_lkp;
    int n_wb;
    int n_upd;
    ccm_pkg::ccm_lkp_s last_cmd;
    logic last_cv;
    logic last_cd;

    ////////////////////////////////////////////////////////////////////////////////
    // Line state comes from address bits 7:6 so the bench can predict it
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wait_q <= 4'h0;
            LKP_ACK <= 1'b0;
            LKP_VALID <= 1'b0;
            LKP_DIRTY <= 1'b0;
            WB_ACK <= 1'b0;
        end
        else
        begin
            LKP_ACK <= 1'b0;
            // Idle answer lines toggle so nothing leans on a stale value
            LKP_VALID <= ~LKP_VALID;
            LKP_DIRTY <= ~LKP_DIRTY;
            if (LKP_REQ && !LKP_ACK)
            begin
                if (wait_q == delay)
                begin
                    LKP_ACK <= 1'b1;
                    LKP_VALID <= LKP_CMD.addr[6];
                    LKP_DIRTY <= LKP_CMD.addr[7];
                    wait_q <= 4'h0;
                end
                else
                begin
                    wait_q <= wait_q + 4'h1;
                end
            end
            WB_ACK <= WB_REQ && !WB_ACK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffers drain only while the sync drain request stands
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            fill_q <= 4'h0;
        else if (fill)
            fill_q <= delay;
        else if (SYNC_DRAIN && fill_q != 4'h0)
            fill_q <= fill_q - 4'h1;
    end
    // Store buffer empties last, so a sync that ignores it ends early
    assign STORE_BUFFER_EMPTY = fill_q == 4'h0;
    assign EVICTION_BUFFER_EMPTY = fill_q <= 4'h1;
    assign WRITE_ALLOCATE_BUFFER_EMPTY = fill_q <= 4'h2;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            n_lkp <= 0;
            n_wb <= 0;
            n_upd <= 0;
        end
        else
        begin
            if (LKP_REQ && LKP_ACK)
            begin
                n_lkp <= n_lkp + 1;
                last_cmd <= LKP_CMD;
            end
            if (WB_REQ && WB_ACK)
                n_wb <= n_wb + 1;
            if (UPD_STB)
            begin
                n_upd <= n_upd + 1;
                last_cv <= UPD_CLR_VALID;
                last_cd <= UPD_CLR_DIRTY;
            end
        end
    end
endmodule

// File: ccm_cfg_decode.sv
`timescale 1ns/10ps
`include "ccm_defines.svh"

module ccm_cfg_decode (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] aux,
    output logic [2:0] wsz_sel,
    output logic [3:0] num_ways,
    output logic [3:0] idx_bits
);

    function automatic logic [2:0] wsz_dec(input logic [2:0] c);
        if (c == 3'h0)
            wsz_dec = `CCM_WSZ_16K;
        else if (c > `CCM_WSZ_MAX_CODE)
            wsz_dec = `CCM_WSZ_256K;
        else
            wsz_dec = c - 3'h1;
    endfunction

    function automatic logic [3:0] asc_dec(input logic [3:0] c);
        asc_dec = (c > `CCM_ASC_MAX) ? `CCM_ASC_MAX : c;
    endfunction

    assign wsz_sel = wsz_dec(aux[`CCM_WSZ_HI:`CCM_WSZ_LO]);
    assign num_ways = asc_dec(aux[`CCM_ASC_HI:`CCM_ASC_LO]);
    // 32-byte lines: 16KB way holds 512 sets
    assign idx_bits = `CCM_MIN_IDX_BITS + {1'b0, wsz_sel};

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    wsz_reserved_a: assert property (
        aux[`CCM_WSZ_HI:`CCM_WSZ_LO] >= 3'h6 |-> wsz_sel == 3'h4 && idx_bits == 4'hd)
        else $error("Reserved way size not mapped to largest");
    asc_reserved_a: assert property (
        aux[`CCM_ASC_HI:`CCM_ASC_LO] >= 4'h9 |-> num_ways == 4'h8)
        else $error("Reserved associativity not mapped to eight ways");
    wsz_low_a: assert property (
        aux[`CCM_WSZ_HI:`CCM_WSZ_LO] <= 3'h1 |-> idx_bits == 4'h9)
        else $error("Smallest way size decoded wrongly");

endmodule

// File: ccm_defines.svh
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

// Register subselect codes
`define CCM_SUB_AUX 4'h0
`define CCM_SUB_SYNC 4'h1
`define CCM_SUB_INV_PA 4'h2
`define CCM_SUB_CLN_IW 4'h3
`define CCM_SUB_CLN_PA 4'h4
`define CCM_SUB_CINV_IW 4'h5
`define CCM_SUB_CINV_PA 4'h6
`define CCM_SUB_INV_WAY 4'h7
`define CCM_SUB_CLN_WAY 4'h8
`define CCM_SUB_CINV_WAY 4'h9
`define CCM_SUB_INV_ALL 4'ha

// Auxiliary configuration layout
`define CCM_AUX_RESET 32'h0002_0fff
`define CCM_AUX_WMASK 32'h01ff_ffff
`define CCM_WSZ_HI 19
`define CCM_WSZ_LO 17
`define CCM_ASC_HI 16
`define CCM_ASC_LO 13
`define CCM_WRAP_BIT 12
`define CCM_DLAT_HI 11
`define CCM_DLAT_LO 9
`define CCM_TLAT_HI 8
`define CCM_TLAT_LO 6
`define CCM_WLAT_HI 5
`define CCM_WLAT_LO 3
`define CCM_RLAT_HI 2
`define CCM_RLAT_LO 0

// Way size and associativity decode
`define CCM_WSZ_16K 3'h0
`define CCM_WSZ_256K 3'h4
`define CCM_WSZ_MAX_CODE 3'h5
`define CCM_ASC_MAX 4'h8
`define CCM_MIN_IDX_BITS 4'h9

// Line address layout
`define CCM_WAY_MASK_ALL 8'hff
`define CCM_IDX_W 13
`define CCM_LINE_LSB 5

`endif

// File: ccm_pkg.sv
package ccm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_BG = 3'b010,
        ST_LOOKUP = 3'b011,
        ST_WBACK = 3'b100,
        ST_UPDATE = 3'b101
    } ccm_state_e;

    typedef struct packed {
        logic line;
        logic by_way;
        logic by_pa;
        logic clean;
        logic inval;
    } ccm_op_s;

    typedef struct packed {
        logic by_pa;
        logic [31:0] addr;
    } ccm_lkp_s;

endpackage

// File: ccm_top.sv
`timescale 1ns/10ps
`include "ccm_defines.svh"

module ccm_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [3:0] REG_SUB,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_STALL,
    output logic [2:0] DIRTY_RAM_LATENCY_OUT,
    output logic [2:0] TAG_RAM_LATENCY_OUT,
    output logic [2:0] DATA_RAM_WRITE_LATENCY_OUT,
    output logic [2:0] DATA_RAM_READ_LATENCY_OUT,
    output logic WRAP_TO_INCR,
    output logic [2:0] WAY_SIZE_SEL,
    output logic [3:0] NUM_WAYS,
    output logic [3:0] INDEX_BITS,
    output logic [7:0] ALLOC_LOCK,
    input wire logic STORE_BUFFER_EMPTY,
    input wire logic EVICTION_BUFFER_EMPTY,
    input wire logic WRITE_ALLOCATE_BUFFER_EMPTY,
    output logic SYNC_DRAIN,
    output logic LKP_REQ,
    output ccm_pkg::ccm_lkp_s LKP_CMD,
    input wire logic LKP_ACK,
    input wire logic LKP_VALID,
    input wire logic LKP_DIRTY,
    output logic WB_REQ,
    input wire logic WB_ACK,
    output logic UPD_STB,
    output logic UPD_CLR_VALID,
    output logic UPD_CLR_DIRTY
);

    ccm_pkg::ccm_state_e state_q;
    ccm_pkg::ccm_state_e state_d;
    ccm_pkg::ccm_op_s op_q;
    ccm_pkg::ccm_op_s req_op;
    ccm_pkg::ccm_lkp_s cmd_q;
    logic [31:0] aux_q;
    logic [31:0] rdata_q;
    logic valid_q;
    logic dirty_q;
    logic busy;
    logic maint_wr;
    logic accept;
    logic all_empty;
    logic eng_start;
    logic [7:0] eng_mask;
    logic eng_step;
    logic eng_busy;
    logic eng_pending;
    logic [7:0] eng_bits;
    logic [31:0] eng_addr;
    logic line_end;

    function automatic ccm_pkg::ccm_op_s op_dec(input logic [3:0] sub);
        ccm_pkg::ccm_op_s o;
        o = '0;
        case (sub)
            `CCM_SUB_INV_PA: o = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
            `CCM_SUB_CLN_IW: o = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
            `CCM_SUB_CLN_PA: o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
            `CCM_SUB_CINV_IW: o = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
            `CCM_SUB_CINV_PA: o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            `CCM_SUB_INV_WAY: o = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            `CCM_SUB_INV_ALL: o = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            `CCM_SUB_CLN_WAY: o = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
            `CCM_SUB_CINV_WAY: o = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            default: o = '0;
        endcase
        return o;
    endfunction

    function automatic logic is_way_sub(input logic [3:0] sub);
        return sub >= `CCM_SUB_INV_WAY && sub <= `CCM_SUB_INV_ALL;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Configuration register
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            aux_q <= `CCM_AUX_RESET;
        else if (REG_WR && REG_SUB == `CCM_SUB_AUX)
            // Takes effect at once, even under a running walk
            aux_q <= REG_WDATA & `CCM_AUX_WMASK;
    end

    assign DIRTY_RAM_LATENCY_OUT = aux_q[`CCM_DLAT_HI:`CCM_DLAT_LO];
    assign TAG_RAM_LATENCY_OUT = aux_q[`CCM_TLAT_HI:`CCM_TLAT_LO];
    assign DATA_RAM_WRITE_LATENCY_OUT = aux_q[`CCM_WLAT_HI:`CCM_WLAT_LO];
    assign DATA_RAM_READ_LATENCY_OUT = aux_q[`CCM_RLAT_HI:`CCM_RLAT_LO];
    assign WRAP_TO_INCR = aux_q[`CCM_WRAP_BIT];

    ccm_cfg_decode u_dec (
        .CLK(CLK),
        .RST_N(RST_N),
        .aux(aux_q),
        .wsz_sel(WAY_SIZE_SEL),
        .num_ways(NUM_WAYS),
        .idx_bits(INDEX_BITS)
    );

    ////////////////////////////////////////////////////////////////
    // Read path
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rdata_q <= 32'h0000_0000;
        else if (REG_RD)
        begin
            if (REG_SUB == `CCM_SUB_AUX)
                rdata_q <= aux_q;
            else if (is_way_sub(REG_SUB))
                rdata_q <= {24'h000000, eng_bits};
            else
                rdata_q <= 32'h0000_0000;
        end
    end

    assign REG_RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////
    // Maintenance request decode
    assign busy = state_q != ccm_pkg::ST_IDLE;
    assign maint_wr = REG_WR && REG_SUB != `CCM_SUB_AUX && REG_SUB <= `CCM_SUB_INV_ALL;
    assign accept = maint_wr && !busy;
    assign req_op = op_dec(REG_SUB);
    assign eng_start = accept && req_op.by_way;
    assign eng_mask = (REG_SUB == `CCM_SUB_INV_ALL) ? `CCM_WAY_MASK_ALL
                                                    : REG_WDATA[7:0];
    assign all_empty = STORE_BUFFER_EMPTY && EVICTION_BUFFER_EMPTY
                       && WRITE_ALLOCATE_BUFFER_EMPTY;

    ccm_way_engine u_eng (
        .CLK(CLK),
        .RST_N(RST_N),
        .start(eng_start),
        .start_mask(eng_mask),
        .start_ways(NUM_WAYS),
        .start_idx_bits(INDEX_BITS),
        .step(eng_step),
        .busy(eng_busy),
        .pending(eng_pending),
        .way_bits(eng_bits),
        .addr(eng_addr)
    );

    // Lookups still hit busy ways; only allocation is barred
    assign ALLOC_LOCK = eng_bits;

    ////////////////////////////////////////////////////////////////
    // Operation sequencer
    always_comb
    begin
        state_d = state_q;
        line_end = 1'b0;
        case (state_q)
            ccm_pkg::ST_IDLE:
                if (accept)
                    state_d = ccm_pkg::ST_SYNC;
            ccm_pkg::ST_SYNC:
                // Linefills in flight are not waited for
                if (all_empty)
                begin
                    if (op_q.line)
                        state_d = ccm_pkg::ST_LOOKUP;
                    else if (op_q.by_way)
                        state_d = ccm_pkg::ST_BG;
                    else
                        state_d = ccm_pkg::ST_IDLE;
                end
            ccm_pkg::ST_BG:
                if (eng_pending)
                    state_d = ccm_pkg::ST_LOOKUP;
                else if (!eng_busy)
                    state_d = ccm_pkg::ST_IDLE;
            ccm_pkg::ST_LOOKUP:
                if (LKP_ACK)
                begin
                    if (!LKP_VALID)
                        line_end = 1'b1;
                    else if (op_q.clean && LKP_DIRTY)
                        state_d = ccm_pkg::ST_WBACK;
                    else if (op_q.inval)
                        state_d = ccm_pkg::ST_UPDATE;
                    else
                        line_end = 1'b1;
                end
            ccm_pkg::ST_WBACK:
                if (WB_ACK)
                    state_d = ccm_pkg::ST_UPDATE;
            ccm_pkg::ST_UPDATE:
                line_end = 1'b1;
            default:
                state_d = ccm_pkg::ST_IDLE;
        endcase
        if (line_end)
            state_d = op_q.by_way ? ccm_pkg::ST_BG : ccm_pkg::ST_IDLE;
    end

    assign eng_step = line_end && op_q.by_way;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_q <= ccm_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            op_q <= '0;
        else if (accept)
            op_q <= req_op;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            cmd_q <= '0;
        else if (accept && req_op.line)
            cmd_q <= '{req_op.by_pa, REG_WDATA};
        else if (state_q == ccm_pkg::ST_BG && eng_pending)
            cmd_q <= '{1'b0, eng_addr};
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            valid_q <= 1'b0;
            dirty_q <= 1'b0;
        end
        else if (state_q == ccm_pkg::ST_LOOKUP && LKP_ACK)
        begin
            valid_q <= LKP_VALID;
            dirty_q <= LKP_DIRTY;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs toward buffers and cache arrays
    assign SYNC_DRAIN = state_q == ccm_pkg::ST_SYNC;
    assign LKP_REQ = state_q == ccm_pkg::ST_LOOKUP;
    assign LKP_CMD = cmd_q;
    assign WB_REQ = state_q == ccm_pkg::ST_WBACK;
    assign UPD_STB = state_q == ccm_pkg::ST_UPDATE;
    assign UPD_CLR_VALID = op_q.inval;
    assign UPD_CLR_DIRTY = op_q.clean;
    // Way walks run without holding the requester
    assign REG_STALL = busy && !op_q.by_way;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    lat_follow_a: assert property (
        REG_WR && REG_SUB == `CCM_SUB_AUX |=>
        DIRTY_RAM_LATENCY_OUT == $past(REG_WDATA[11:9])
        && DATA_RAM_READ_LATENCY_OUT == $past(REG_WDATA[2:0]))
        else $error("Latency outputs do not follow the written fields");
    wrap_follow_a: assert property (
        REG_WR && REG_SUB == `CCM_SUB_AUX |=> WRAP_TO_INCR == $past(REG_WDATA[12]))
        else $error("Wrap suppress output does not follow the register");
    sync_first_a: assert property (
        accept |=> state_q == ccm_pkg::ST_SYNC && SYNC_DRAIN)
        else $error("Maintenance request did not start with a sync");
    sync_hold_a: assert property (
        state_q == ccm_pkg::ST_SYNC && !all_empty |=> state_q == ccm_pkg::ST_SYNC)
        else $error("Sync finished while a buffer still held data");
    sync_leave_a: assert property (
        state_q == ccm_pkg::ST_SYNC && all_empty |=> state_q != ccm_pkg::ST_SYNC)
        else $error("Sync did not finish once buffers were empty");
    busy_ignore_a: assert property (
        busy && maint_wr |=> op_q == $past(op_q) && eng_bits == ($past(eng_bits) & eng_bits))
        else $error("Request taken while a task was running");
    line_stall_a: assert property (
        accept && req_op.line |=> REG_STALL [*2])
        else $error("Line operation did not stall the requester");
    way_nostall_a: assert property (
        accept && req_op.by_way |=> !REG_STALL)
        else $error("Way operation stalled the requester");
    wb_cause_a: assert property (
        WB_REQ |-> valid_q && dirty_q && op_q.clean)
        else $error("Write-back issued for a clean, invalid or uncleaned line");
    lock_start_a: assert property (
        eng_start && REG_SUB != `CCM_SUB_INV_ALL |=> ALLOC_LOCK == $past(REG_WDATA[7:0]))
        else $error("Selected ways not locked against allocation");
    all_ways_a: assert property (
        accept && REG_SUB == `CCM_SUB_INV_ALL |=> ALLOC_LOCK == 8'hff)
        else $error("Invalidate all did not select every way");
    inv_miss_a: assert property (
        state_q == ccm_pkg::ST_LOOKUP && LKP_ACK && !LKP_VALID |=> !UPD_STB && !WB_REQ)
        else $error("Invalid line touched by maintenance");

    sync_only_c: cover property (
        accept && REG_SUB == `CCM_SUB_SYNC ##[1:20] state_q == ccm_pkg::ST_IDLE);
    line_wb_c: cover property (WB_REQ && WB_ACK ##1 UPD_STB);
    way_done_c: cover property (
        state_q == ccm_pkg::ST_BG && !eng_busy && op_q.by_way && op_q.inval);
    ignored_c: cover property (busy && maint_wr);

endmodule

// File: ccm_way_engine.sv
`timescale 1ns/10ps
`include "ccm_defines.svh"

module ccm_way_engine (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic start,
    input wire logic [7:0] start_mask,
    input wire logic [3:0] start_ways,
    input wire logic [3:0] start_idx_bits,
    input wire logic step,
    output logic busy,
    output logic pending,
    output logic [7:0] way_bits,
    output logic [31:0] addr
);

    logic [7:0] bits_q;
    logic [3:0] nways_q;
    logic [3:0] ibits_q;
    logic [`CCM_IDX_W-1:0] idx_q;
    logic [2:0] cur;
    logic cur_ok;
    logic skip;
    logic [`CCM_IDX_W-1:0] last_idx;

    function automatic logic [2:0] lowest(input logic [7:0] b);
        lowest = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (b[i])
                lowest = 3'(i);
        end
    endfunction

    assign cur = lowest(bits_q);
    assign cur_ok = {1'b0, cur} < nways_q;
    assign busy = |bits_q;
    assign pending = busy && cur_ok;
    // Ways beyond the configured associativity hold no lines
    assign skip = busy && !cur_ok;
    assign last_idx = ~(13'h1fff << ibits_q);
    assign way_bits = bits_q;
    assign addr = {cur, 11'h000, idx_q, 5'h00};

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            nways_q <= 4'h0;
            ibits_q <= 4'h0;
        end
        else if (start)
        begin
            // Latched so an aux write cannot reshape a running walk
            nways_q <= start_ways;
            ibits_q <= start_idx_bits;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bits_q <= 8'h00;
            idx_q <= '0;
        end
        else if (start)
        begin
            bits_q <= start_mask;
            idx_q <= '0;
        end
        else if (skip || (step && idx_q == last_idx))
        begin
            bits_q[cur] <= 1'b0;
            idx_q <= '0;
        end
        else if (step)
            idx_q <= idx_q + 13'h1;
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    bits_only_clear_a: assert property (
        !start |=> (bits_q & ~$past(bits_q)) == 8'h00)
        else $error("Way bit set without a new request");
    bit_held_a: assert property (
        pending && !step |=> bits_q == $past(bits_q))
        else $error("Way bit cleared before its way finished");

endmodule
